// [common/vic_pkg.sv]
// constants shared by the vectored interrupt controller files
// assumes a 32-bit AHB-Lite slave port, one word per register
package vic_pkg;

    // geometry
    localparam int VIC_NSRC       = 32;
    localparam int VIC_NEST_DEPTH = 8;
    localparam int VIC_EV_W       = 2;

    // register byte offsets within the slave window
    localparam logic [11:0] VIC_SMR_BASE = 12'h000;
    localparam logic [11:0] VIC_SVR_BASE = 12'h080;
    localparam logic [11:0] VIC_IVR      = 12'h100;
    localparam logic [11:0] VIC_FVR      = 12'h104;
    localparam logic [11:0] VIC_ISR      = 12'h108;
    localparam logic [11:0] VIC_IPR      = 12'h10C;
    localparam logic [11:0] VIC_IMR      = 12'h110;
    localparam logic [11:0] VIC_CISR     = 12'h114;
    localparam logic [11:0] VIC_IECR     = 12'h120;
    localparam logic [11:0] VIC_IDCR     = 12'h124;
    localparam logic [11:0] VIC_ICCR     = 12'h128;
    localparam logic [11:0] VIC_ISCR     = 12'h12C;
    localparam logic [11:0] VIC_EOICR    = 12'h130;
    localparam logic [11:0] VIC_SPU      = 12'h134;
    localparam logic [11:0] VIC_DCR      = 12'h138;
    localparam logic [11:0] VIC_FFER     = 12'h140;
    localparam logic [11:0] VIC_FFDR     = 12'h144;
    localparam logic [11:0] VIC_FFSR     = 12'h148;
    localparam logic [11:0] VIC_EVSR     = 12'h150;
    localparam logic [11:0] VIC_EVMR     = 12'h154;

    // field positions
    localparam int VIC_SMR_PRIO_LSB = 0;
    localparam int VIC_SMR_TYPE_LSB = 5;
    localparam int VIC_DCR_PROT_BIT = 0;
    localparam int VIC_DCR_GMSK_BIT = 1;
    localparam int VIC_EV_SPUR_BIT  = 0;
    localparam int VIC_EV_FAST_BIT  = 1;

    // trigger type: bit0 selects edge, bit1 selects high/rising
    localparam logic [1:0] VIC_TYP_LEVEL_LO = 2'h0;
    localparam logic [1:0] VIC_TYP_EDGE_FAL = 2'h1;
    localparam logic [1:0] VIC_TYP_LEVEL_HI = 2'h2;
    localparam logic [1:0] VIC_TYP_EDGE_RIS = 2'h3;

    // sources wired to pins, which honour the polarity bit
    localparam logic [31:0] VIC_EXT_MASK = 32'hE000_0001;

    // bus phase
    typedef enum logic [0:0] {
        VIC_BUS_IDLE = 1'b0,
        VIC_BUS_DATA = 1'b1
    } vic_bus_type;

endpackage : vic_pkg

// [logic/vic_vec_mem.sv]
// per-source vector store, one write port and one registered read
// assumes write and read addresses are stable around the clock edge
`timescale 1ns/100ps
module vic_vec_mem
    import vic_pkg::*;
#(
    parameter int W  = 32,
    parameter int D  = VIC_NSRC,
    parameter int AW = 5
)(
    // clock and reset
    input  wire logic          clock,
    input  wire logic          resetn,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    // read port
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [W-1:0]        rdata;
    } vic_mem_type;

    vic_mem_type s;
    vic_mem_type nxt_s;

    always_comb begin
        nxt_s = s;
        nxt_s.rdata = s.mem[raddr];
        if (we) begin
            nxt_s.mem[waddr] = wdata;
        end
    end

    // reset keeps every vector defined, at a cost of flops not RAM
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= nxt_s;
        end
    end

    assign rdata = s.rdata;

endmodule : vic_vec_mem

// [logic/vic_src_detect.sv]
// per-source trigger conditioning: polarity and edge detection
// assumes request inputs are already synchronous to the clock
`timescale 1ns/100ps
module vic_src_detect
    import vic_pkg::*;
#(
    parameter int N = VIC_NSRC
)(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // requests and their trigger types
    input  wire logic [N-1:0]      raw,
    input  wire logic [N-1:0][1:0] typ,
    // conditioned requests
    output logic      [N-1:0]      lvl_act,
    output logic      [N-1:0]      edge_hit
);

    typedef struct packed {
        logic [N-1:0] prev;
    } vic_det_type;

    vic_det_type s;
    vic_det_type nxt_s;

    // internal sources are always active high or rising
    for (genvar i = 0; i < N; i++) begin : g_src
        assign lvl_act[i]  = raw[i] ^ (VIC_EXT_MASK[i] & ~typ[i][1]);
        assign edge_hit[i] = lvl_act[i] & ~s.prev[i];
    end

    always_comb begin
        nxt_s = s;
        nxt_s.prev = lvl_act;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= nxt_s;
        end
    end

endmodule : vic_src_detect

// [logic/vic_top.sv]
// vectored nested-priority interrupt controller with AHB-Lite slave
// assumes single word transfers and requests synchronous to clock
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module vic_top
    import vic_pkg::*;
#(
    parameter int NEST_DEPTH = VIC_NEST_DEPTH
)(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    // interrupt requests
    input  wire logic        fast_irq_pin,
    input  wire logic        system_periph_request,
    input  wire logic [28:2] periph_req,
    input  wire logic        ext_irq_pin_0,
    input  wire logic        ext_irq_pin_1,
    input  wire logic        ext_irq_pin_2,
    // processor lines and own event interrupt
    output logic             normal_irq_out_n,
    output logic             fast_irq_out_n,
    output logic             irq_out
);

    ////////////////////////////////////////////////////////////////////

    typedef struct packed {
        vic_bus_type                  bus;
        logic                         wr;
        logic [11:0]                  addr;
        logic [4:0]                   lat_src;
        logic                         lat_ok;
        logic                         hready;
        logic [31:0]                  hrdata;
        logic [31:0]                  enable;
        logic [31:0]                  edge_pend;
        logic [31:0]                  ffast;
        logic [31:0]                  spu;
        logic [1:0]                   dcr;
        logic [VIC_EV_W-1:0]          ev_stat;
        logic [VIC_EV_W-1:0]          ev_mask;
        logic [31:0][2:0]             prio;
        logic [31:0][1:0]             typ;
        logic [NEST_DEPTH-1:0][2:0]   stk_prio;
        logic [NEST_DEPTH-1:0][4:0]   stk_src;
        logic [3:0]                   depth;
        logic                         normal_irq_out_n_n;
        logic                         fast_irq_out_n_n;
        logic                         irq;
    } vic_state_type;

    vic_state_type       s;
    vic_state_type       nxt_s;
    logic [31:0]         raw;
    logic [31:0]         lvl_act;
    logic [31:0]         edge_hit;
    logic [31:0]         edge_mode;
    logic [31:0]         ipr;
    logic [31:0]         act;
    logic [31:0]         cand;
    logic [31:0]         clr;
    logic [31:0]         sw_set;
    logic [VIC_EV_W-1:0] w1c;
    logic [VIC_EV_W-1:0] ev_set;
    logic                found;
    logic [4:0]          best_src;
    logic [2:0]          best_prio;
    logic [2:0]          cur_prio;
    logic [4:0]          cur_src;
    logic                fiq_want;
    logic                acc;
    logic                prot;
    logic                gmsk;
    logic                mem_we;
    logic [4:0]          mem_raddr;
    logic [31:0]         mem_rdata;

    ////////////////////////////////////////////////////////////////////

    // bit position is the peripheral identifier
    assign raw = {ext_irq_pin_2, ext_irq_pin_1, ext_irq_pin_0,
                  periph_req,
                  system_periph_request,
                  fast_irq_pin};

    vic_src_detect #(
        .N        (VIC_NSRC)
    ) u_detect (
        .clock    (clock),
        .resetn   (resetn),
        .raw      (raw),
        .typ      (s.typ),
        .lvl_act  (lvl_act),
        .edge_hit (edge_hit)
    );

    vic_vec_mem #(
        .W        (32),
        .D        (VIC_NSRC),
        .AW       (5)
    ) u_vectors (
        .clock    (clock),
        .resetn   (resetn),
        .we       (mem_we),
        .waddr    (s.addr[6:2]),
        .wdata    (hwdata),
        .raddr    (mem_raddr),
        .rdata    (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////

    always_comb begin
        nxt_s = s;
        for (int i = 0; i < VIC_NSRC; i++) begin
            edge_mode[i] = s.typ[i][0];
        end
        ipr  = (s.edge_pend & edge_mode) | (lvl_act & ~edge_mode);
        act  = ipr & s.enable;
        cand = act & ~s.ffast & ~32'h0000_0001;
        prot = s.dcr[VIC_DCR_PROT_BIT];
        gmsk = s.dcr[VIC_DCR_GMSK_BIT];
        cur_prio = 3'h0;
        cur_src  = 5'h00;
        if (s.depth != 4'h0) begin
            cur_prio = s.stk_prio[s.depth - 4'h1];
            cur_src  = s.stk_src[s.depth - 4'h1];
        end
        // ties go to the lowest source number
        found     = 1'b0;
        best_src  = 5'h00;
        best_prio = 3'h0;
        for (int i = 1; i < VIC_NSRC; i++) begin
            if (cand[i] && (s.depth == 4'h0 || s.prio[i] > cur_prio)
                && (!found || s.prio[i] > best_prio)) begin
                found     = 1'b1;
                best_src  = 5'(i);
                best_prio = s.prio[i];
            end
        end
        fiq_want = act[0] | (|(act & s.ffast));
        nxt_s.normal_irq_out_n_n = ~(found & ~gmsk);
        nxt_s.fast_irq_out_n_n = ~(fiq_want & ~gmsk);
        // vector read address is set up in the address phase
        acc = hsel & hready & htrans[1];
        mem_raddr = 5'h00;
        if (acc) begin
            if (haddr[11:0] == VIC_IVR) begin
                mem_raddr = best_src;
            end else if (haddr[11:0] != VIC_FVR) begin
                mem_raddr = haddr[6:2];
            end
        end
        mem_we = 1'b0;
        clr    = 32'h0000_0000;
        sw_set = 32'h0000_0000;
        w1c    = '0;
        ev_set = '0;
        if (acc) begin
            nxt_s.bus     = VIC_BUS_DATA;
            nxt_s.hready  = 1'b0;
            nxt_s.wr      = hwrite;
            nxt_s.addr    = haddr[11:0];
            nxt_s.lat_src = best_src;
            nxt_s.lat_ok  = found;
        end else if (s.bus == VIC_BUS_DATA) begin
            nxt_s.bus    = VIC_BUS_IDLE;
            nxt_s.hready = 1'b1;
            nxt_s.hrdata = 32'h0000_0000;
            if (s.wr) begin
                if (s.addr < VIC_SVR_BASE) begin
                    nxt_s.prio[s.addr[6:2]] = hwdata[VIC_SMR_PRIO_LSB +: 3];
                    nxt_s.typ[s.addr[6:2]]  = hwdata[VIC_SMR_TYPE_LSB +: 2];
                end else if (s.addr < VIC_IVR) begin
                    mem_we = 1'b1;
                end else if (s.addr == VIC_IECR) begin
                    nxt_s.enable = s.enable | hwdata;
                end else if (s.addr == VIC_IDCR) begin
                    nxt_s.enable = s.enable & ~hwdata;
                end else if (s.addr == VIC_ICCR) begin
                    clr = hwdata;
                end else if (s.addr == VIC_ISCR) begin
                    sw_set = hwdata;
                end else if (s.addr == VIC_EOICR) begin
                    if (s.depth != 4'h0) begin
                        nxt_s.depth = s.depth - 4'h1;
                    end
                end else if (s.addr == VIC_SPU) begin
                    nxt_s.spu = hwdata;
                end else if (s.addr == VIC_DCR) begin
                    nxt_s.dcr = hwdata[1:0];
                end else if (s.addr == VIC_FFER) begin
                    nxt_s.ffast = s.ffast | hwdata;
                end else if (s.addr == VIC_FFDR) begin
                    nxt_s.ffast = s.ffast & ~hwdata;
                end else if (s.addr == VIC_EVSR) begin
                    w1c = hwdata[VIC_EV_W-1:0];
                end else if (s.addr == VIC_EVMR) begin
                    nxt_s.ev_mask = hwdata[VIC_EV_W-1:0];
                end
            end else begin
                if (s.addr < VIC_SVR_BASE) begin
                    nxt_s.hrdata[VIC_SMR_PRIO_LSB +: 3] = s.prio[s.addr[6:2]];
                    nxt_s.hrdata[VIC_SMR_TYPE_LSB +: 2] = s.typ[s.addr[6:2]];
                end else if (s.addr < VIC_IVR) begin
                    nxt_s.hrdata = mem_rdata;
                end else if (s.addr == VIC_IVR) begin
                    // a full stack still answers but does not nest deeper
                    if (s.lat_ok) begin
                        nxt_s.hrdata = mem_rdata;
                        if (!prot && s.depth < 4'(NEST_DEPTH)) begin
                            nxt_s.stk_prio[s.depth] = s.prio[s.lat_src];
                            nxt_s.stk_src[s.depth]  = s.lat_src;
                            nxt_s.depth = s.depth + 4'h1;
                            clr[s.lat_src] = 1'b1;
                        end
                    end else begin
                        nxt_s.hrdata = s.spu;
                        ev_set[VIC_EV_SPUR_BIT] = ~prot;
                    end
                end else if (s.addr == VIC_FVR) begin
                    nxt_s.hrdata = fiq_want ? mem_rdata : s.spu;
                    clr[0] = ~prot;
                end else if (s.addr == VIC_ISR) begin
                    nxt_s.hrdata[4:0] = cur_src;
                end else if (s.addr == VIC_IPR) begin
                    nxt_s.hrdata = ipr;
                end else if (s.addr == VIC_IMR) begin
                    nxt_s.hrdata = s.enable;
                end else if (s.addr == VIC_CISR) begin
                    nxt_s.hrdata[1:0] = {~s.fast_irq_out_n_n, ~s.normal_irq_out_n_n};
                end else if (s.addr == VIC_SPU) begin
                    nxt_s.hrdata = s.spu;
                end else if (s.addr == VIC_DCR) begin
                    nxt_s.hrdata[1:0] = s.dcr;
                end else if (s.addr == VIC_FFSR) begin
                    nxt_s.hrdata = s.ffast;
                end else if (s.addr == VIC_EVSR) begin
                    nxt_s.hrdata[VIC_EV_W-1:0] = s.ev_stat;
                end else if (s.addr == VIC_EVMR) begin
                    nxt_s.hrdata[VIC_EV_W-1:0] = s.ev_mask;
                end
            end
        end
        // a new edge wins over a clear in the same cycle
        nxt_s.edge_pend = (s.edge_pend & ~clr) | edge_hit | sw_set;
        ev_set[VIC_EV_FAST_BIT] = s.fast_irq_out_n_n & ~nxt_s.fast_irq_out_n_n;
        nxt_s.ev_stat = (s.ev_stat & ~w1c) | ev_set;
        nxt_s.irq = |(nxt_s.ev_stat & nxt_s.ev_mask);
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            s        <= '0;
            s.hready <= 1'b1;
            s.normal_irq_out_n_n <= 1'b1;
            s.fast_irq_out_n_n <= 1'b1;
        end else begin
            s <= nxt_s;
        end
    end

    assign hreadyout        = s.hready;
    assign hrdata           = s.hrdata;
    assign hresp            = 1'b0;
    assign normal_irq_out_n = s.normal_irq_out_n_n;
    assign fast_irq_out_n   = s.fast_irq_out_n_n;
    assign irq_out          = s.irq;

    ////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    logic rd_ivr_a;
    assign rd_ivr_a = s.bus == VIC_BUS_DATA && !s.wr && s.addr == VIC_IVR;

    chk_gmask_lines: assert property (
        gmsk && nxt_s.dcr[VIC_DCR_GMSK_BIT] |=>
            normal_irq_out_n && fast_irq_out_n)
        else $error("general mask failed to hold lines high");

    chk_src0_fast: assert property (
        act[0] && !gmsk && !nxt_s.dcr[VIC_DCR_GMSK_BIT] |=>
            !fast_irq_out_n)
        else $error("source 0 did not raise fast line");

    chk_src0_not_normal: assert property (
        (act & ~s.ffast) == 32'h0000_0001 |=> normal_irq_out_n)
        else $error("source 0 reached normal line");

    chk_normal_assert: assert property (
        found && !gmsk && !nxt_s.dcr[VIC_DCR_GMSK_BIT] |=>
            !normal_irq_out_n)
        else $error("pending source did not raise normal line");

    chk_force_fast: assert property (
        (act & s.ffast & ~32'h0000_0001) != 32'h0000_0000
        && !gmsk && !nxt_s.dcr[VIC_DCR_GMSK_BIT] |=>
            !fast_irq_out_n)
        else $error("forced source did not raise fast line");

    chk_nest_higher: assert property (
        found && s.depth != 4'h0 |-> best_prio > cur_prio)
        else $error("nesting by priority not strictly higher");

    chk_ivr_push: assert property (
        rd_ivr_a && !prot && s.lat_ok && s.depth < 4'(NEST_DEPTH) |=>
            s.depth == $past(s.depth) + 4'h1
            && hrdata == $past(mem_rdata))
        else $error("vector read did not enter service");

    chk_protect_ivr: assert property (
        rd_ivr_a && prot |=> s.depth == $past(s.depth)
            && s.ev_stat[VIC_EV_SPUR_BIT] == $past(s.ev_stat[0]))
        else $error("protected vector read changed state");

    chk_edge_hold: assert property (
        clr == 32'h0000_0000 |=>
            ($past(s.edge_pend) & ~s.edge_pend) == 32'h0000_0000)
        else $error("edge pending lost without a clear");

    chk_bus_wait: assert property (
        acc |=> !hreadyout ##1 hreadyout)
        else $error("slave answer timing wrong");

    cov_nest_two: cover property (s.depth == 4'h2);
    cov_spurious: cover property (rd_ivr_a && !s.lat_ok);
    cov_forced: cover property (!fast_irq_out_n && s.ffast != 32'h0);
    cov_gmask_pend: cover property (gmsk && found);

endmodule : vic_top

// [sim/vic_core_model.sv]
// core-side model: counts requests arriving on the two processor lines
// assumes both lines are active-low levels driven from flops
`timescale 1ns/100ps
module vic_core_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // processor lines
    input  wire logic       normal_irq_out_n,
    input  wire logic       fast_irq_out_n,
    // request counts
    output logic      [7:0] nrm_cnt,
    output logic      [7:0] fst_cnt
);
    logic nrm_ff;
    logic fst_ff;
    ////////////////////////////////////////////////////////////////////////
    // a falling line is one request taken; level stays until serviced
    always @(posedge clock) begin
        if (!resetn) begin
            nrm_ff  <= 1'b1;
            fst_ff  <= 1'b1;
            nrm_cnt <= 8'h00;
            fst_cnt <= 8'h00;
        end else begin
            nrm_ff <= normal_irq_out_n;
            fst_ff <= fast_irq_out_n;
            if (nrm_ff && !normal_irq_out_n) nrm_cnt <= nrm_cnt + 8'h01;
            if (fst_ff && !fast_irq_out_n) fst_cnt <= fst_cnt + 8'h01;
        end
    end
endmodule : vic_core_model

// [sim/vectored_priority_interrupt_controller_test.sv]
// self-checking bench for the vectored interrupt controller
// assumes vic_top alone on the bus, hready looped from hreadyout
`timescale 1ns/100ps
module vectored_priority_interrupt_controller_test;
    import vic_pkg::*;
    typedef struct packed {
        logic [1:0]  typ;
        logic        idle;
        logic [31:0] vec;
    } vic_row_type;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        fast_irq_pin = 1'b0;
    logic        system_periph_request = 1'b0;
    logic [28:2] periph_req = '0;
    logic        ext_irq_pin_0 = 1'b1;
    logic        ext_irq_pin_1 = 1'b1;
    logic        ext_irq_pin_2 = 1'b1;
    logic        hreadyout, hresp, irq_out;
    logic        normal_irq_out_n, fast_irq_out_n;
    logic [31:0] hrdata, rd;
    logic [7:0]  fst_cnt;
    int          n_mismatch = 0;
    int          comparisons = 0;
    vic_row_type rows [4] = '{'{VIC_TYP_LEVEL_LO, 1'b1, 32'h0000_A100},
                              '{VIC_TYP_EDGE_FAL, 1'b1, 32'h0000_A201},
                              '{VIC_TYP_LEVEL_HI, 1'b0, 32'h0000_A302},
                              '{VIC_TYP_EDGE_RIS, 1'b0, 32'h0000_A403}};
    always #4 clock = ~clock;
    vic_top vic_top_inst (.clock(clock), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .fast_irq_pin(fast_irq_pin),
        .system_periph_request(system_periph_request),
        .periph_req(periph_req), .ext_irq_pin_0(ext_irq_pin_0),
        .ext_irq_pin_1(ext_irq_pin_1), .ext_irq_pin_2(ext_irq_pin_2),
        .normal_irq_out_n(normal_irq_out_n),
        .fast_irq_out_n(fast_irq_out_n), .irq_out(irq_out));
    vic_core_model vic_core_model_inst (.clock(clock), .resetn(resetn),
        .normal_irq_out_n(normal_irq_out_n), .fast_irq_out_n(fast_irq_out_n),
        .nrm_cnt(), .fst_cnt(fst_cnt));
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic chk32(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk32
    // bounded wait for a line level; running out counts as a mismatch
    task automatic wait_sig(input string nm, input int sel, input logic l);
        int k;
        logic v;
        k = 0;
        v = (sel == 0) ? normal_irq_out_n : (sel == 1) ? fast_irq_out_n
                                                        : irq_out;
        while (v !== l && k < 20) begin
            @(posedge clock);
            k++;
            v = (sel == 0) ? normal_irq_out_n : (sel == 1) ? fast_irq_out_n
                                                            : irq_out;
        end
        chk32(nm, {31'h0, l}, {31'h0, v});
        if (v !== l) summarize();
    endtask : wait_sig
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
    endtask : wait_rdy
    // one single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input string nm, input logic [11:0] a,
                         input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk32(nm, e, rd);
    endtask : rdchk
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clock);
        chk32("reset lines", 32'h3, {30'h0, normal_irq_out_n, fast_irq_out_n});
        chk32("reset bus", 32'h4, {29'h0, hreadyout, hresp, irq_out});
        resetn <= 1'b1;
        // trigger-type table on the third external pin
        wr(VIC_IECR, 32'h8000_0000);
        foreach (rows[i]) begin
            wr(VIC_SMR_BASE + 12'h07C, {25'h0, rows[i].typ, 5'h01});
            wr(VIC_SVR_BASE + 12'h07C, rows[i].vec);
            ext_irq_pin_2 <= rows[i].idle;
            wr(VIC_ICCR, 32'h8000_0000);
            repeat (3) @(posedge clock);
            chk32("idle line", 32'h1, {31'h0, normal_irq_out_n});
            ext_irq_pin_2 <= ~rows[i].idle;
            wait_sig("type line", 0, 1'b0);
            rdchk("type vector", VIC_IVR, rows[i].vec);
            ext_irq_pin_2 <= rows[i].idle;
            wr(VIC_EOICR, 32'h0);
        end
        wr(VIC_IDCR, 32'h8000_0000);
        // nesting: system source at 2, first pin at 5
        ext_irq_pin_0 <= 1'b0;
        wr(VIC_SMR_BASE + 12'h004, 32'h0000_0042);
        wr(VIC_SMR_BASE + 12'h074, 32'h0000_0045);
        wr(VIC_SVR_BASE + 12'h004, 32'h0000_1001);
        wr(VIC_SVR_BASE + 12'h074, 32'h0000_101D);
        wr(VIC_IECR, 32'h2000_0002);
        rdchk("imr", VIC_IMR, 32'h2000_0002);
        system_periph_request <= 1'b1;
        wait_sig("sys line", 0, 1'b0);
        rdchk("sys vector", VIC_IVR, 32'h0000_1001);
        rdchk("isr sys", VIC_ISR, 32'h0000_0001);
        repeat (4) @(posedge clock);
        chk32("no equal nest", 32'h1, {31'h0, normal_irq_out_n});
        ext_irq_pin_0 <= 1'b1;
        wait_sig("nest line", 0, 1'b0);
        rdchk("pin vector", VIC_IVR, 32'h0000_101D);
        rdchk("isr pin", VIC_ISR, 32'h0000_001D);
        ext_irq_pin_0 <= 1'b0;
        system_periph_request <= 1'b0;
        wr(VIC_EOICR, 32'h0);
        wr(VIC_EOICR, 32'h0);
        wr(VIC_IDCR, 32'h2000_0002);
        // fast source, forcing and general mask
        wr(VIC_SMR_BASE, 32'h0000_0040);
        wr(VIC_SVR_BASE, 32'h0000_F000);
        wr(VIC_IECR, 32'h0000_0021);
        fast_irq_pin <= 1'b1;
        wait_sig("fast line", 1, 1'b0);
        chk32("nrm quiet", 32'h1, {31'h0, normal_irq_out_n});
        rdchk("fast vector", VIC_FVR, 32'h0000_F000);
        fast_irq_pin <= 1'b0;
        wait_sig("fast off", 1, 1'b1);
        wr(VIC_SMR_BASE + 12'h014, 32'h0000_0047);
        wr(VIC_FFER, 32'h0000_0020);
        rdchk("force status", VIC_FFSR, 32'h0000_0020);
        periph_req[5] <= 1'b1;
        wait_sig("forced fast", 1, 1'b0);
        chk32("forced nrm", 32'h1, {31'h0, normal_irq_out_n});
        wr(VIC_FFDR, 32'h0000_0020);
        wait_sig("unforced nrm", 0, 1'b0);
        wr(VIC_DCR, 32'h0000_0002);
        wait_sig("masked nrm", 0, 1'b1);
        rdchk("masked ipr", VIC_IPR, 32'h0000_0020);
        periph_req[5] <= 1'b0;
        wr(VIC_DCR, 32'h0);
        wr(VIC_IDCR, 32'h0000_0021);
        // protect mode: vector read leaves latch and stack alone
        wr(VIC_SMR_BASE + 12'h018, 32'h0000_0063);
        wr(VIC_SVR_BASE + 12'h018, 32'h0000_2006);
        wr(VIC_IECR, 32'h0000_0040);
        wr(VIC_DCR, 32'h0000_0001);
        periph_req[6] <= 1'b1;
        @(posedge clock);
        periph_req[6] <= 1'b0;
        wait_sig("edge line", 0, 1'b0);
        rdchk("prot vector", VIC_IVR, 32'h0000_2006);
        rdchk("prot ipr", VIC_IPR, 32'h0000_0040);
        rdchk("prot isr", VIC_ISR, 32'h0);
        wr(VIC_DCR, 32'h0);
        rdchk("edge vector", VIC_IVR, 32'h0000_2006);
        rdchk("edge cleared", VIC_IPR, 32'h0);
        wr(VIC_EOICR, 32'h0);
        wr(VIC_IDCR, 32'h0000_0040);
        // spurious event: raise, mask, unmask, clear
        wr(VIC_SPU, 32'h0000_5A5A);
        wr(VIC_EVSR, 32'h0000_0003);
        wr(VIC_EVMR, 32'h0000_0001);
        rdchk("spurious", VIC_IVR, 32'h0000_5A5A);
        wait_sig("event irq", 2, 1'b1);
        rdchk("event status", VIC_EVSR, 32'h0000_0001);
        wr(VIC_EVMR, 32'h0);
        wait_sig("event masked", 2, 1'b0);
        wr(VIC_EVMR, 32'h0000_0001);
        wait_sig("event unmasked", 2, 1'b1);
        wr(VIC_EVSR, 32'h0000_0001);
        wait_sig("event cleared", 2, 1'b0);
        rdchk("unmapped", 12'hFFC, 32'h0);
        chk32("fast count", 32'h2, {24'h0, fst_cnt});
        // mid-run reset with enables and general mask programmed
        wr(VIC_IECR, 32'h0000_0002);
        wr(VIC_DCR, 32'h0000_0002);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        chk32("rerun lines", 32'h7,
              {29'h0, normal_irq_out_n, fast_irq_out_n, hreadyout});
        rdchk("rerun imr", VIC_IMR, 32'h0);
        rdchk("rerun dcr", VIC_DCR, 32'h0);
        summarize();
    end
endmodule : vectored_priority_interrupt_controller_test
